/* shared/fhc_pkg.sv */
package fhc_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 25;

    // Pin timing that the host keeps, in nanoseconds
    localparam int RESET_PULSE_NS = 100;
    localparam int OUT_VALID_NS = 150;
    localparam int WRITE_DELAY_NS = 100;
    localparam int ABORT_NS = 22000;
    localparam int ACCESS_NS = 90;
    localparam int WE_PULSE_NS = 60;
    localparam int ADDR_SETUP_NS = 10;
    localparam int DATA_HOLD_NS = 10;

    // Least times, rounded up to whole cycles
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OUT_VALID_CYC = (OUT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_DELAY_CYC = (WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ABORT_CYC = (ABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Read data passes two sampling stages before capture
    localparam int SYNC_STAGES = 2;

    // Timer and counter widths
    localparam int TMR_W = 10;
    localparam logic [TMR_W-1:0] TMR_MAX = 10'h3FF;

    // Commands that start an internal alter sequence
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h20;

    // Ready bit of the status byte
    localparam int STATUS_READY_BIT = 7;

    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_RESET = 3'b001,
        ST_IDLE = 3'b010,
        ST_READ = 3'b011,
        ST_WR_SETUP = 3'b100,
        ST_WR_PULSE = 3'b101,
        ST_WR_HOLD = 3'b110
    } fhc_state_e;

endpackage

/* shared/fhc_tmr_if.sv */
interface fhc_tmr_if;
    import fhc_pkg::*;

    logic load;
    logic [TMR_W-1:0] count;
    logic expired;

    modport ctrl (output load, output count, input expired);
    modport timer (input load, input count, output expired);
endinterface

/* sim/fhc_flash_model.sv */
module fhc_flash_model #(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int ACC_NS = 60,
    parameter int BUSY_NS = 3000,
    parameter logic [15:0] ID_MFR = 16'h00A5, // Arbitrary value
    parameter logic [15:0] ID_DEV = 16'h005C, // Arbitrary value
    parameter logic SUPPLY_LOW = 1'b0,
    parameter logic WP_N = 1'b1
) (
    // Control pins
    input wire logic rpN,
    input wire logic csN,
    input wire logic oeN,
    input wire logic weN,
    // Address and data pins
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] dq,
    output logic [DW-1:0] dqOut
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DW-1:0] mem [16];
    logic [1:0] mode;
    logic [1:0] pend;
    logic isErase;
    logic [3:0] lastAddr;
    logic [7:0] status;
    int busyLeft;
    logic [DW-1:0] rdVal, rdDly, lastOut;
    logic on, driveDly;
    logic locked;

    // Array geometry; only a small window of words is modelled
    localparam int PARAM_BLOCKS = 8;
    localparam int PARAM_BLOCK_WORDS = 4096;
    localparam int MAIN_BLOCK_WORDS = 32768;
    localparam int MAIN_BLOCKS = (AW == 22) ? 63 : (AW == 21) ? 31 : (AW == 20) ? 15 : 7;

    // Power-up contents and defaults
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = DW'(32'h0000_1000 + i);
        mode = 2'd0;
        pend = 2'd0;
        status = 8'h80;
        busyLeft = 0;
        lastOut = '0;
        locked = 1'b1;
    end

    // Leaving reset locks the lockable word again
    always @(posedge rpN) locked = 1'b1;

    // Alter timer keeps running whether selected or not
    always #10 if (busyLeft != 0) busyLeft = busyLeft - 1;

    // Read mux: array, status or identifier
    always @* begin
        case (mode)
            2'd0: rdVal = mem[addr[3:0]];
            2'd1: rdVal = DW'({busyLeft == 0, status[6:0]});
            default: rdVal = (addr[AW-1:1] == 0) ? DW'(addr[0] ? ID_DEV : ID_MFR) : '0;
        endcase
    end

    // Drive only in the read bus state, after a slow access time
    assign on = rpN && !csN && !oeN && weN;
    assign #(ACC_NS) driveDly = on;
    assign #(ACC_NS) rdDly = rdVal;
    // Released bus shows the inverse, so a stale value never passes
    always @(negedge driveDly) lastOut = rdDly;
    assign dqOut = driveDly ? rdDly : ~lastOut;

    // Latch on whichever strobe rises first
    always @(posedge weN) if (rpN && !csN && oeN) command(addr, dq);
    always @(posedge csN) if (rpN && !weN && oeN) command(addr, dq);

    // Reset: abort, invalidate target, back to read array
    always @(negedge rpN) begin
        if (busyLeft != 0) begin
            if (isErase) for (int i = 0; i < 16; i++) mem[i] = ~mem[i];
            else mem[lastAddr] = ~mem[lastAddr];
        end
        busyLeft = 0;
        mode = 2'd0;
        pend = 2'd0;
        status = 8'h80;
    end

    task automatic command(input logic [AW-1:0] a, input logic [DW-1:0] d);
        if (pend == 2'd1) begin
            if (locked && !WP_N && a[3:0] == 4'h0) begin
                status[4] = 1'b1;
                status[1] = 1'b1;
            end else begin
                mem[a[3:0]] = d;
                lastAddr = a[3:0];
                isErase = 1'b0;
                busyLeft = BUSY_NS / 10;
            end
            pend = 2'd0;
        end else if (pend == 2'd2) begin
            if (d[7:0] == 8'hD0 && locked && !WP_N) begin
                status[5] = 1'b1;
                status[1] = 1'b1;
            end else if (d[7:0] == 8'hD0) begin
                for (int i = 0; i < 16; i++) mem[i] = '1;
                isErase = 1'b1;
                busyLeft = BUSY_NS / 10;
            end else status[5:4] = 2'b11;
            pend = 2'd0;
        end else begin
            case (d[7:0])
                8'h40, 8'h10: if (!SUPPLY_LOW) pend = 2'd1;
                8'h20: if (!SUPPLY_LOW) pend = 2'd2;
                8'hFF: mode = 2'd0;
                8'h70: mode = 2'd1;
                8'h90: mode = 2'd2;
                8'h50: status[5:1] = 5'h00;
                default: ;
            endcase
            if (pend != 2'd0) mode = 2'd1;
        end
    endtask
endmodule

/* sim/tb_top.sv */
module tb_top
    import fhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
    localparam logic [15:0] DEV = 16'h005C; // Arbitrary value

    logic core_clk, rst, reqValid, reqWrite, resetReq;
    logic [21:0] reqAddr, flashAddr;
    logic [15:0] reqData, rspData, dataOut, modelOut, dataBus, r;
    logic reqReady, rspDone, opActive, resetPowerdownN, chipSelectN;
    logic outputEnableN, writeEnableN, dataOe;
    int errTotal, nChecks, lowCnt, lastLow, sinceRise;

    // Host wins the wire while it drives
    assign dataBus = dataOe ? dataOut : modelOut;

    fhc_flash_host u_fhc_flash_host (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .resetReq(resetReq),
        .reqReady(reqReady), .rspData(rspData), .rspDone(rspDone), .opActive(opActive),
        .resetPowerdownN(resetPowerdownN), .chipSelectN(chipSelectN),
        .outputEnableN(outputEnableN), .writeEnableN(writeEnableN), .flashAddr(flashAddr),
        .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataBus));

    fhc_flash_model #(.ACC_NS(80), .ID_MFR(MFR), .ID_DEV(DEV)) u_fhc_flash_model (
        .rpN(resetPowerdownN), .csN(chipSelectN), .oeN(outputEnableN), .weN(writeEnableN),
        .addr(flashAddr), .dq(dataBus), .dqOut(modelOut));

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One request, held until its completion pulse
    task automatic op(input logic w, input logic [21:0] a, input logic [15:0] d,
                      output logic [15:0] rd);
        int n;
        @(posedge core_clk) #1;
        reqValid = 1'b1;
        reqWrite = w;
        reqAddr = a;
        reqData = d;
        n = 0;
        do begin
            @(posedge core_clk) #1;
            n++;
        end while (rspDone !== 1'b1 && n < 2000);
        if (n >= 2000) check("request completion", 16'h0000, 16'h0001);
        rd = rspData;
        check("ready with done", 16'(reqReady), 16'h0001);
        reqValid = 1'b0;
    endtask

    task automatic wr(input logic [21:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        op(1'b1, a, d, dummy);
    endtask

    // Poll status until the alter sequence reports ready
    task automatic pollReady();
        int n;
        n = 0;
        do begin
            op(1'b0, 22'h0, 16'h0, r);
            n++;
        end while (r[7] !== 1'b1 && n < 200);
    endtask

    // Reset pin low time and cycles since it last rose
    always @(posedge core_clk) begin
        if (resetPowerdownN === 1'b0) begin
            lowCnt++;
            sinceRise = 0;
        end else begin
            if (lowCnt != 0) lastLow = lowCnt;
            lowCnt = 0;
            sinceRise++;
        end
    end

    // Pin states at the start of each read and write strobe
    always @(negedge outputEnableN) if (!rst) begin
        check("read pins", {resetPowerdownN, writeEnableN, chipSelectN}, 16'h0006);
        check("read recovery", 16'(sinceRise >= OUT_VALID_CYC), 16'h0001);
    end
    always @(negedge writeEnableN) if (!rst) begin
        check("write pins", {resetPowerdownN, outputEnableN, chipSelectN}, 16'h0006);
        check("write recovery", 16'(sinceRise >= WRITE_DELAY_CYC), 16'h0001);
    end

    initial begin
        #(30000 * CLK_PERIOD_NS);
        errTotal++;
        conclude();
    end

    initial begin
        {core_clk, reqValid, reqWrite, resetReq} = 4'b0000;
        rst = 1'b1;
        reqAddr = '0;
        reqData = '0;
        errTotal = 0;
        nChecks = 0;
        lowCnt = 0;
        lastLow = 0;
        sinceRise = 0;
        repeat (4) @(posedge core_clk);
        #1;
        check("reset pin in reset", {resetPowerdownN, chipSelectN}, 16'h0001);
        rst = 1'b0;
        op(1'b0, 22'h3, 16'h0, r);
        check("first read", r, 16'h1003);
        wr(22'h2, 16'h0040);
        wr(22'h2, 16'h1234);
        check("alter active", 16'(opActive), 16'h0001);
        op(1'b0, 22'h2, 16'h0, r);
        check("busy status", r, 16'h0000);
        pollReady();
        check("ready status", r, 16'h0080);
        check("alter done", 16'(opActive), 16'h0000);
        wr(22'h0, 16'h00FF);
        op(1'b0, 22'h2, 16'h0, r);
        check("programmed word", r, 16'h1234);
        wr(22'h0, 16'h0020);
        wr(22'h0, 16'h00D0);
        pollReady();
        wr(22'h0, 16'h00FF);
        op(1'b0, 22'h5, 16'h0, r);
        check("erased word", r, 16'hFFFF);
        wr(22'h0, 16'h0090);
        op(1'b0, 22'h0, 16'h0, r);
        check("maker code", r, MFR);
        op(1'b0, 22'h1, 16'h0, r);
        check("device code", r, DEV);
        // Plain reset, then an abort during programming
        @(posedge core_clk) #1 resetReq = 1'b1;
        @(posedge core_clk) #1 resetReq = 1'b0;
        op(1'b0, 22'h4, 16'h0, r);
        check("read after reset", r, 16'hFFFF);
        check("reset pulse", 16'(lastLow), 16'(RESET_PULSE_CYC));
        wr(22'h2, 16'h0040);
        wr(22'h2, 16'h5678);
        @(posedge core_clk) #1 resetReq = 1'b1;
        @(posedge core_clk) #1 resetReq = 1'b0;
        op(1'b0, 22'h2, 16'h0, r);
        check("aborted word", r, 16'hA987);
        check("abort shutdown", 16'(lastLow), 16'(ABORT_CYC));
        check("alter cleared", 16'(opActive), 16'h0000);
        conclude();
    end
endmodule

/* src/fhc_flash_host.sv */
module fhc_flash_host
    import fhc_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // User requests
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqData,
    input wire logic resetReq,
    output logic reqReady,
    output logic [DATA_W-1:0] rspData,
    output logic rspDone,
    output logic opActive,
    // Flash pins
    output logic resetPowerdownN,
    output logic chipSelectN,
    output logic outputEnableN,
    output logic writeEnableN,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic [DATA_W-1:0] dataIn
);

    fhc_tmr_if tmr ();

    fhc_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .tmr(tmr)
    );

    fhc_state_e state_q, state_d;
    logic [TMR_W-1:0] recov_q, recov_d;
    logic setupPend_q, setupPend_d;
    logic opActive_q, opActive_d;
    logic abortHold_q, abortHold_d;
    logic reqReady_q, reqReady_d;
    logic rspDone_q, rspDone_d;
    logic [DATA_W-1:0] rspData_q, rspData_d;
    logic [DATA_W-1:0] sync1_q, sync2_q;
    logic rpN_q, rpN_d, csN_q, csN_d, oeN_q, oeN_d, weN_q, weN_d, dOe_q, dOe_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dOut_q, dOut_d;
    logic tmrLoad;
    logic [TMR_W-1:0] tmrCount;
    logic canRead, canWrite, alterCmd;

    // Reads and writes held off until the flash has woken up
    assign canRead = (recov_q >= TMR_W'(OUT_VALID_CYC));
    assign canWrite = (recov_q >= TMR_W'(WRITE_DELAY_CYC));
    // Decode the latched word; the user may move reqData once the request is taken
    assign alterCmd = (dOut_q[7:0] == CMD_PROGRAM) || (dOut_q[7:0] == CMD_PROGRAM_ALT)
        || (dOut_q[7:0] == CMD_ERASE);

    // Sequencer next state and timer loads
    always_comb begin
        state_d = state_q;
        tmrLoad = 1'b0;
        tmrCount = '0;
        abortHold_d = abortHold_q;
        if (resetReq && state_q != ST_BOOT && state_q != ST_RESET) begin
            // Running alter needs the full shutdown before release
            state_d = ST_RESET;
            tmrLoad = 1'b1;
            abortHold_d = opActive_q;
            tmrCount = opActive_q ? TMR_W'(ABORT_CYC - 1) : TMR_W'(RESET_PULSE_CYC - 1);
        end else begin
            unique case (state_q)
                ST_BOOT: begin
                    state_d = ST_RESET;
                    tmrLoad = 1'b1;
                    tmrCount = TMR_W'(RESET_PULSE_CYC - 1);
                end
                ST_RESET: begin
                    if (tmr.expired) begin
                        state_d = ST_IDLE;
                        abortHold_d = 1'b0;
                    end
                end
                ST_IDLE: begin
                    if (reqValid && reqReady_q && reqWrite && canWrite) begin
                        state_d = ST_WR_SETUP;
                        tmrLoad = 1'b1;
                        tmrCount = TMR_W'(ADDR_SETUP_CYC - 1);
                    end else if (reqValid && reqReady_q && !reqWrite && canRead) begin
                        state_d = ST_READ;
                        tmrLoad = 1'b1;
                        tmrCount = TMR_W'(ACCESS_CYC + SYNC_STAGES - 1);
                    end
                end
                ST_READ: begin
                    if (tmr.expired) begin
                        state_d = ST_IDLE;
                    end
                end
                ST_WR_SETUP: begin
                    if (tmr.expired) begin
                        state_d = ST_WR_PULSE;
                        tmrLoad = 1'b1;
                        tmrCount = TMR_W'(WE_PULSE_CYC - 1);
                    end
                end
                ST_WR_PULSE: begin
                    if (tmr.expired) begin
                        state_d = ST_WR_HOLD;
                        tmrLoad = 1'b1;
                        tmrCount = TMR_W'(DATA_HOLD_CYC - 1);
                    end
                end
                ST_WR_HOLD: begin
                    if (tmr.expired) begin
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_BOOT;
                end
            endcase
        end
    end

    // Pin levels follow the state being entered
    always_comb begin
        rpN_d = 1'b1;
        csN_d = 1'b1;
        oeN_d = 1'b1;
        weN_d = 1'b1;
        dOe_d = 1'b0;
        addr_d = addr_q;
        dOut_d = dOut_q;
        unique case (state_d)
            ST_BOOT, ST_RESET: rpN_d = 1'b0;
            ST_READ: begin
                csN_d = 1'b0;
                oeN_d = 1'b0;
            end
            ST_WR_SETUP, ST_WR_HOLD: begin
                csN_d = 1'b0;
                dOe_d = 1'b1;
            end
            ST_WR_PULSE: begin
                csN_d = 1'b0;
                weN_d = 1'b0;
                dOe_d = 1'b1;
            end
            default: begin
            end
        endcase
        // Address and data latched once, so they stay still at strobe rise
        if (state_q == ST_IDLE && state_d != ST_IDLE && state_d != ST_RESET) begin
            addr_d = reqAddr;
            dOut_d = reqData;
        end
    end

    // Status, recovery counter and answers
    always_comb begin
        recov_d = recov_q;
        if (state_d == ST_RESET || state_d == ST_BOOT) begin
            recov_d = '0;
        end else if (recov_q != TMR_MAX) begin
            recov_d = recov_q + 1'b1;
        end
        setupPend_d = setupPend_q;
        opActive_d = opActive_q;
        rspDone_d = 1'b0;
        rspData_d = rspData_q;
        if (state_q == ST_READ && state_d == ST_IDLE) begin
            rspDone_d = 1'b1;
            rspData_d = sync2_q;
            // Ready in status ends the tracked operation
            if (sync2_q[STATUS_READY_BIT]) begin
                opActive_d = 1'b0;
            end
        end
        if (state_q == ST_WR_HOLD && state_d == ST_IDLE) begin
            rspDone_d = 1'b1;
            setupPend_d = alterCmd && !setupPend_q;
            if (setupPend_q) begin
                opActive_d = 1'b1;
            end
        end
        if (state_d == ST_RESET || state_d == ST_BOOT) begin
            // Reset ends or aborts any operation; device is back in array mode
            setupPend_d = 1'b0;
            opActive_d = 1'b0;
        end
        reqReady_d = (state_d == ST_IDLE) && !(state_q == ST_IDLE && reqValid && reqReady_q);
    end

    // Registers; data pins sampled through two stages since they are asynchronous
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_BOOT;
            recov_q <= '0;
            setupPend_q <= 1'b0;
            opActive_q <= 1'b0;
            abortHold_q <= 1'b0;
            reqReady_q <= 1'b0;
            rspDone_q <= 1'b0;
            rspData_q <= '0;
            sync1_q <= '0;
            sync2_q <= '0;
            rpN_q <= 1'b0;
            csN_q <= 1'b1;
            oeN_q <= 1'b1;
            weN_q <= 1'b1;
            dOe_q <= 1'b0;
            addr_q <= '0;
            dOut_q <= '0;
        end else begin
            state_q <= state_d;
            recov_q <= recov_d;
            setupPend_q <= setupPend_d;
            opActive_q <= opActive_d;
            abortHold_q <= abortHold_d;
            reqReady_q <= reqReady_d;
            rspDone_q <= rspDone_d;
            rspData_q <= rspData_d;
            sync1_q <= dataIn;
            sync2_q <= sync1_q;
            rpN_q <= rpN_d;
            csN_q <= csN_d;
            oeN_q <= oeN_d;
            weN_q <= weN_d;
            dOe_q <= dOe_d;
            addr_q <= addr_d;
            dOut_q <= dOut_d;
        end
    end

    assign tmr.load = tmrLoad;
    assign tmr.count = tmrCount;

    assign reqReady = reqReady_q;
    assign rspData = rspData_q;
    assign rspDone = rspDone_q;
    assign opActive = opActive_q;
    assign resetPowerdownN = rpN_q;
    assign chipSelectN = csN_q;
    assign outputEnableN = oeN_q;
    assign writeEnableN = weN_q;
    assign flashAddr = addr_q;
    assign dataOut = dOut_q;
    assign dataOe = dOe_q;

    // Helper: cycles the reset pin has been low
    logic [TMR_W-1:0] rpLow_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rpLow_q <= '0;
        end else if (rpN_q) begin
            rpLow_q <= '0;
        end else if (rpLow_q != TMR_MAX) begin
            rpLow_q <= rpLow_q + 1'b1;
        end
    end

    AST_READ_PINS: assert property (@(posedge core_clk) disable iff (rst)
        !oeN_q |-> (!csN_q && weN_q && rpN_q))
        else $error("read strobe without select or with write or reset");
    AST_WRITE_PINS: assert property (@(posedge core_clk) disable iff (rst)
        !weN_q |-> (!csN_q && oeN_q && rpN_q && dOe_q))
        else $error("write strobe with bad control levels");
    AST_NO_FIGHT: assert property (@(posedge core_clk) disable iff (rst)
        dOe_q |-> oeN_q)
        else $error("host drives data while flash output enabled");
    AST_RESET_FOLLOWS: assert property (@(posedge core_clk)
        rst |=> !rpN_q)
        else $error("flash reset not asserted with system reset");
    AST_PULSE_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        $rose(rpN_q) |-> (rpLow_q >= TMR_W'(RESET_PULSE_CYC)))
        else $error("reset pulse too short");
    AST_ABORT_WAIT: assert property (@(posedge core_clk) disable iff (rst)
        ($rose(rpN_q) && $past(abortHold_q)) |-> (rpLow_q >= TMR_W'(ABORT_CYC)))
        else $error("reset released before abort shutdown ended");
    AST_READ_WAKE: assert property (@(posedge core_clk) disable iff (rst)
        $fell(oeN_q) |-> (recov_q > TMR_W'(OUT_VALID_CYC)))
        else $error("read started before output valid delay");
    AST_WRITE_WAKE: assert property (@(posedge core_clk) disable iff (rst)
        $fell(weN_q) |-> (recov_q > TMR_W'(WRITE_DELAY_CYC)))
        else $error("write started before reset to write delay");
    AST_LATCH_STABLE: assert property (@(posedge core_clk) disable iff (rst)
        $rose(weN_q) |-> ($stable(addr_q) && $stable(dOut_q) && dOe_q && !csN_q))
        else $error("address or data moved at write strobe rise");
    AST_ALTER_TRACK: assert property (@(posedge core_clk) disable iff (rst || resetReq)
        ($rose(opActive_q)) |-> $past(state_q) == ST_WR_HOLD)
        else $error("operation tracked without a confirming write");

endmodule

/* src/fhc_timer.sv */
module fhc_timer
    import fhc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    fhc_tmr_if.timer tmr
);

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;

    // Load N gives N+1 cycles until expiry
    always_comb begin
        if (tmr.load) begin
            cnt_d = tmr.count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end else begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tmr.expired = (cnt_q == '0);

endmodule
